/* File: hw/dst_pkg.sv */
// package: register map, field positions and carrier types of the diagnostic status block
package dst_pkg;
   // byte addresses of the command word (word address = byte address with bit 0 dropped)
   localparam logic [6:0] DIAG_ADDR = 7'h3C;
   localparam logic [6:0] MISC_ADDR = 7'h34;
   // diagnostic status field positions
   localparam int ACC_FAIL_LSB = 13;
   localparam int GYRO_FAIL_LSB = 10;
   localparam int ALM_LSB = 8;
   localparam int UNUSED_BIT = 7;
   localparam int FLASH_CK_BIT = 6;
   localparam int ST_ERR_BIT = 5;
   localparam int OVR_BIT = 4;
   localparam int SPI_FAIL_BIT = 3;
   localparam int FLASH_UPD_BIT = 2;
   localparam int SUP_HI_BIT = 1;
   localparam int SUP_LO_BIT = 0;
   localparam logic [15:0] DIAG_RESET = 16'h0000;
   localparam logic [15:0] STICKY_MASK = 16'hFF7C;
   localparam logic [15:0] LIVE_MASK = 16'h0003;
   // misc control field positions
   localparam int MEM_TEST_BIT = 11;
   localparam int AUTO_ST_BIT = 10;
   localparam int STIM_NEG_BIT = 9;
   localparam int STIM_POS_BIT = 8;
   localparam logic [15:0] MISC_RESET = 16'h0006;
   localparam logic [15:0] MISC_WMASK = 16'h0FC7;
   // self-test result width: accel z,y,x then gyro z,y,x
   localparam int ST_RES_W = 6;

   // condition levels from the monitoring logic
   typedef struct packed {
      logic [1:0] alarm;
      logic overrange;
      logic spi_fail;
      logic flash_upd_fail;
      logic supply_hi;
      logic supply_lo;
   } dst_cond_s;

   // one command word: write flag, byte address, write data
   typedef struct packed {
      logic wr;
      logic [6:0] addr;
      logic [7:0] data;
   } dst_cmd_s;
endpackage

/* File: hw/dst_job.sv */
// module: request/complete tracker for one test job with result capture
module dst_job #(
   parameter int RES_W = 1
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic start_in,
   input wire logic done_in,
   input wire logic [RES_W-1:0] res_in,
   output logic busy_out,
   output logic fin_out,
   output logic [RES_W-1:0] res_out
);
   typedef enum logic [1:0] {
      JOB_IDLE = 2'b01,
      JOB_RUN = 2'b10
   } dst_job_state_e;

   dst_job_state_e state_r;
   dst_job_state_e state_nxt;
   logic [RES_W-1:0] res_r;

   // completion is only taken while a job runs
   assign fin_out = (state_r == JOB_RUN) && done_in && ce_in;
   assign busy_out = (state_r == JOB_RUN);
   assign res_out = res_r;

   // next state: start ignored while running
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         JOB_IDLE: begin
            if (start_in) begin
               state_nxt = JOB_RUN;
            end
         end
         JOB_RUN: begin
            if (done_in) begin
               state_nxt = JOB_IDLE;
            end
         end
         default: begin
            state_nxt = JOB_IDLE;
         end
      endcase
   end

   // state and result registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r <= JOB_IDLE;
         res_r <= '0;
      end else if (ce_in) begin
         state_r <= state_nxt;
         if (fin_out) begin
            res_r <= res_in;
         end
      end
   end

   chk_job_fin_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
      fin_out |=> state_r == JOB_IDLE && res_r == $past(res_in))
      else $error("job did not finish cleanly");
endmodule // dst_job

/* File: hw/dst_diag_status.sv */
// module: diagnostic status flags, misc control and test job launch
module dst_diag_status (
   input wire logic CLK_SYS_IN,
   input wire logic NRST_IN,
   input wire logic CE_IN,
   input wire logic SAMPLE_TICK_IN,
   input wire logic CMD_VALID_IN,
   input wire dst_pkg::dst_cmd_s CMD_IN,
   input wire dst_pkg::dst_cond_s COND_IN,
   input wire logic ST_DONE_IN,
   input wire logic [dst_pkg::ST_RES_W-1:0] ST_RESULT_IN,
   input wire logic MEM_DONE_IN,
   input wire logic MEM_FAIL_IN,
   output logic [15:0] RD_DATA_OUT,
   output logic RD_VALID_OUT,
   output logic [15:0] CTRL_OUT,
   output logic STIM_NEG_OUT,
   output logic STIM_POS_OUT,
   output logic ST_REQ_OUT,
   output logic MEM_REQ_OUT
);
   logic [15:0] diag_r;
   logic [15:0] diag_nxt;
   logic [15:0] misc_r;
   logic [15:0] misc_nxt;
   logic [15:0] rd_data_r;
   logic rd_valid_r;
   logic [15:0] rd_data_nxt;
   logic cmd_rd;
   logic cmd_wr;
   logic hit_diag;
   logic hit_misc;
   logic rd_clr;
   logic wr_misc_lo;
   logic wr_misc_hi;
   logic st_start;
   logic mem_start;
   logic st_fin;
   logic mem_fin;
   logic st_busy;
   logic mem_busy;
   logic [dst_pkg::ST_RES_W-1:0] st_res;
   logic mem_res;
   logic [15:0] cond_vec;
   logic [15:0] ev_vec;
   logic [15:0] set_vec;

   // command decode
   assign cmd_rd = CMD_VALID_IN && !CMD_IN.wr;
   assign cmd_wr = CMD_VALID_IN && CMD_IN.wr;
   assign hit_diag = CMD_IN.addr[6:1] == dst_pkg::DIAG_ADDR[6:1];
   assign hit_misc = CMD_IN.addr[6:1] == dst_pkg::MISC_ADDR[6:1];
   assign rd_clr = cmd_rd && hit_diag && CE_IN;
   assign wr_misc_lo = cmd_wr && hit_misc && !CMD_IN.addr[0];
   assign wr_misc_hi = cmd_wr && hit_misc && CMD_IN.addr[0];
   // read mux, unmapped reads return zero
   assign rd_data_nxt = hit_diag ? diag_r : (hit_misc ? misc_r : 16'h0000);

   // job launch from the self-clearing control bits
   assign st_start = wr_misc_hi && CMD_IN.data[dst_pkg::AUTO_ST_BIT-8];
   assign mem_start = wr_misc_hi && CMD_IN.data[dst_pkg::MEM_TEST_BIT-8];

   // self-test job tracker
   dst_job #(.RES_W(dst_pkg::ST_RES_W)) u_st_job (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .ce_in(CE_IN),
      .start_in(st_start),
      .done_in(ST_DONE_IN),
      .res_in(ST_RESULT_IN),
      .busy_out(st_busy),
      .fin_out(st_fin),
      .res_out(st_res)
   );

   // memory checksum job tracker
   dst_job #(.RES_W(1)) u_mem_job (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .ce_in(CE_IN),
      .start_in(mem_start),
      .done_in(MEM_DONE_IN),
      .res_in(MEM_FAIL_IN),
      .busy_out(mem_busy),
      .fin_out(mem_fin),
      .res_out(mem_res)
   );

   // persisting conditions laid out as status bits, bit 7 constant zero
   assign cond_vec = {st_res, COND_IN.alarm, 1'b0, mem_res, |st_res, COND_IN.overrange,
                      COND_IN.spi_fail, COND_IN.flash_upd_fail, COND_IN.supply_hi,
                      COND_IN.supply_lo};
   // job completions set their flags at once
   assign ev_vec = {(st_fin ? ST_RESULT_IN : 6'h00), 3'h0, mem_fin && MEM_FAIL_IN,
                    st_fin && (|ST_RESULT_IN), 5'h00};
   assign set_vec = (SAMPLE_TICK_IN ? cond_vec : 16'h0000) | ev_vec;

   // per-bit next value: sticky set-over-clear, live supply bits, constant zero
   generate
      for (genvar i = 0; i < 16; i++) begin : g_flag
         if (dst_pkg::LIVE_MASK[i]) begin : g_live
            assign diag_nxt[i] = SAMPLE_TICK_IN ? cond_vec[i] :
                                 (diag_r[i] && !rd_clr);
         end else if (dst_pkg::STICKY_MASK[i]) begin : g_sticky
            assign diag_nxt[i] = (diag_r[i] && !rd_clr) || set_vec[i];
         end else begin : g_zero
            assign diag_nxt[i] = 1'b0;
         end
      end
   endgenerate

   // control register: byte writes, done clears run bits unless rewritten
   always_comb begin
      misc_nxt = misc_r;
      if (st_fin) begin
         misc_nxt[dst_pkg::AUTO_ST_BIT] = 1'b0;
      end
      if (mem_fin) begin
         misc_nxt[dst_pkg::MEM_TEST_BIT] = 1'b0;
      end
      if (wr_misc_lo) begin
         misc_nxt[7:0] = CMD_IN.data & dst_pkg::MISC_WMASK[7:0];
      end
      if (wr_misc_hi) begin
         misc_nxt[15:8] = CMD_IN.data & dst_pkg::MISC_WMASK[15:8];
      end
   end

   // status flags, writes never reach them
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         diag_r <= dst_pkg::DIAG_RESET;
      end else if (CE_IN) begin
         diag_r <= diag_nxt;
      end
   end

   // control register and read answer
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         misc_r <= dst_pkg::MISC_RESET;
         rd_data_r <= 16'h0000;
         rd_valid_r <= 1'b0;
      end else if (CE_IN) begin
         misc_r <= misc_nxt;
         rd_valid_r <= cmd_rd;
         if (cmd_rd) begin
            rd_data_r <= rd_data_nxt;
         end
      end
   end

   // outputs straight from flops
   assign RD_DATA_OUT = rd_data_r;
   assign RD_VALID_OUT = rd_valid_r;
   assign CTRL_OUT = misc_r;
   assign STIM_NEG_OUT = misc_r[dst_pkg::STIM_NEG_BIT];
   assign STIM_POS_OUT = misc_r[dst_pkg::STIM_POS_BIT];
   assign ST_REQ_OUT = st_busy;
   assign MEM_REQ_OUT = mem_busy;

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!NRST_IN);

   // checks
   chk_read_clears_all: assert property (rd_clr && !SAMPLE_TICK_IN && !st_fin && !mem_fin
      |=> diag_r == 16'h0000)
      else $error("read did not clear status");
   chk_flag_sets_again: assert property (rd_clr ##1 (CE_IN && SAMPLE_TICK_IN
      && COND_IN.overrange) |=> diag_r[dst_pkg::OVR_BIT])
      else $error("persisting condition not set again");
   chk_supply_drops: assert property (CE_IN && SAMPLE_TICK_IN && !COND_IN.supply_hi
      && !COND_IN.supply_lo |=> diag_r[1:0] == 2'b00)
      else $error("supply flags did not drop");
   chk_accel_fail: assert property (st_fin |=> (diag_r[15:13] & $past(ST_RESULT_IN[5:3]))
      == $past(ST_RESULT_IN[5:3]))
      else $error("accel failure not reported");
   chk_gyro_fail: assert property (st_fin |=> (diag_r[12:10] & $past(ST_RESULT_IN[2:0]))
      == $past(ST_RESULT_IN[2:0]))
      else $error("gyro failure not reported");
   chk_alarm_bits: assert property (CE_IN && SAMPLE_TICK_IN && COND_IN.alarm == 2'b10
      |=> diag_r[9])
      else $error("alarm two not shown");
   chk_flash_result: assert property (mem_fin && MEM_FAIL_IN |=> diag_r[6])
      else $error("checksum failure not loaded");
   chk_st_summary: assert property (st_fin && (|ST_RESULT_IN) |=> diag_r[5])
      else $error("summary error not set");
   chk_overrange_bit: assert property (CE_IN && SAMPLE_TICK_IN && COND_IN.overrange
      |=> diag_r[4])
      else $error("overrange not flagged");
   chk_link_flash_bits: assert property (CE_IN && SAMPLE_TICK_IN && COND_IN.spi_fail
      && COND_IN.flash_upd_fail |=> diag_r[3:2] == 2'b11)
      else $error("link or update failure not flagged");
   chk_supply_high: assert property (CE_IN && SAMPLE_TICK_IN && COND_IN.supply_hi
      |=> diag_r[1])
      else $error("high supply not shown");
   chk_supply_low: assert property (CE_IN && SAMPLE_TICK_IN && COND_IN.supply_lo
      |=> diag_r[0])
      else $error("low supply not shown");
   chk_auto_clears: assert property (st_fin && !wr_misc_hi |=> !misc_r[10])
      else $error("self-test bit not cleared");
   chk_mem_launch: assert property (CE_IN && mem_start && !mem_busy |=> MEM_REQ_OUT)
      else $error("memory job not started");
   chk_stim_drive: assert property (CE_IN && wr_misc_hi |=> {STIM_NEG_OUT, STIM_POS_OUT}
      == $past(CMD_IN.data[1:0]))
      else $error("stimulus not driven");
   chk_unused_write: assert property (diag_r[7] == 1'b0 and (CE_IN && cmd_wr && hit_diag
      && !SAMPLE_TICK_IN && !st_fin && !mem_fin && !rd_clr |=> $stable(diag_r)))
      else $error("status changed by write");

   cov_read_flags: cover property (rd_clr && diag_r != 16'h0000);
   cov_st_done: cover property (st_fin && (|ST_RESULT_IN));
   cov_mem_done: cover property (mem_fin);
   cov_set_on_clear: cover property (rd_clr && SAMPLE_TICK_IN && COND_IN.overrange);
endmodule // dst_diag_status

/* File: bench/dst_host_model.sv */
// host model: sends command words to the diagnostic status block
module dst_host_model #(
   parameter int SETTLE_CYC = 20
) (
   input wire logic clk_in,
   input wire logic rd_valid_in,
   input wire logic [15:0] rd_data_in,
   output logic cmd_valid_out,
   output dst_pkg::dst_cmd_s cmd_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_valid_out = 1'b0;
      cmd_out = '0;
   end
   // one word, held across one rising edge
   task automatic send(input logic is_wr, input logic [6:0] addr, input logic [7:0] data);
      @(negedge clk_in);
      cmd_valid_out = 1'b1;
      cmd_out = '{wr: is_wr, addr: addr, data: data};
      @(negedge clk_in);
      cmd_valid_out = 1'b0;
      cmd_out = ~cmd_out; // released lines lose the old word
   endtask
   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      send(1'b1, addr, data);
   endtask
   // read answer awaited under a bound
   task automatic rd(input logic [6:0] addr, output logic [15:0] data, output logic ok);
      send(1'b0, addr, 8'h00);
      ok = 1'b0;
      data = 16'h0000;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rd_valid_in === 1'b1) begin
            data = rd_data_in;
            ok = 1'b1;
         end else begin
            @(negedge clk_in);
         end
      end
   endtask
   // fastest period, widest range, four taps, settle, baseline
   task automatic manual_setup(output logic [15:0] base, output logic ok);
      wr(7'h36, 8'h01);
      wr(7'h39, 8'h04);
      wr(7'h38, 8'h02);
      repeat (SETTLE_CYC) @(negedge clk_in);
      rd(7'h04, base, ok);
   endtask
   // stimulus phase, settle, x rate read; code 00 ends the
   task automatic manual_phase(input logic [7:0] code, output logic [15:0] rate, output logic ok);
      wr(7'h35, code);
      repeat (SETTLE_CYC) @(negedge clk_in);
      rd(7'h04, rate, ok);
   endtask
endmodule // dst_host_model

/* File: bench/tb_dst_diag_status.sv */
// testbench: diagnostic status flags, misc control and test jobs
module tb_dst_diag_status;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] ROW_COND [8] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02,
      7'h01, 7'h7F};
   localparam logic [15:0] ROW_EXP [8] = '{16'h0200, 16'h0100, 16'h0010, 16'h0008,
      16'h0004, 16'h0002, 16'h0001, 16'h031F};
   localparam logic [7:0] STIM_CODE [3] = '{8'h02, 8'h01, 8'h00};
   logic clk, nrst, tick, st_done, mem_done, mem_fail, cmd_valid, rd_valid;
   logic stim_neg, stim_pos, st_req, mem_req, ok, ce;
   logic [5:0] st_res;
   logic [15:0] rd_data, ctrl, rd_d;
   dst_pkg::dst_cond_s cond;
   dst_pkg::dst_cmd_s cmd;
   int error_cnt, checks_done;
   dst_diag_status dst_diag_status_inst (.CLK_SYS_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
      .SAMPLE_TICK_IN(tick), .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd), .COND_IN(cond),
      .ST_DONE_IN(st_done), .ST_RESULT_IN(st_res), .MEM_DONE_IN(mem_done),
      .MEM_FAIL_IN(mem_fail), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid),
      .CTRL_OUT(ctrl), .STIM_NEG_OUT(stim_neg), .STIM_POS_OUT(stim_pos),
      .ST_REQ_OUT(st_req), .MEM_REQ_OUT(mem_req));
   dst_host_model dst_host_model_inst (.clk_in(clk), .rd_valid_in(rd_valid),
      .rd_data_in(rd_data), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
   // clock generation
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp, input string what);
      logic [15:0] d;
      logic got_ok;
      dst_host_model_inst.rd(addr, d, got_ok);
      if (got_ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: no read answer", $time);
         tally_and_finish();
      end else begin
         chk(d, exp, what);
      end
   endtask
   task automatic pulse_tick();
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
   endtask
   // job launch and done pulse with bounded wait on the request
   task automatic run_job(input logic mem, input logic [7:0] code);
      int n;
      n = 0;
      dst_host_model_inst.wr(7'h35, code);
      while (((mem ? mem_req : st_req) !== 1'b1) && n < 8) begin
         @(negedge clk);
         n++;
      end
      if (n == 8) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: job request missing", $time);
         tally_and_finish();
      end
      chk(ctrl & {4'h0, code[3:2], 10'h000}, {4'h0, code[3:2], 10'h000}, "job bit set");
      mem_done = mem;
      st_done = ~mem;
      @(negedge clk);
      mem_done = 1'b0;
      st_done = 1'b0;
      chk({12'h000, mem_req, st_req, ctrl[11:10]}, 16'h0000, "job bit not cleared");
   endtask
   // main sequence
   initial begin
      {nrst, tick, st_done, mem_done, mem_fail, st_res, cond} = '0;
      ce = 1'b1;
      error_cnt = 0;
      checks_done = 0;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      chk(ctrl, dst_pkg::MISC_RESET, "misc reset");
      chk(rd_data, 16'h0000, "read data reset");
      chk({11'h000, rd_valid, stim_neg, stim_pos, st_req, mem_req}, 16'h0000, "outputs reset");
      rd_chk(dst_pkg::DIAG_ADDR, 16'h0000, "diag reset");
      for (int i = 0; i < 8; i++) begin
         cond = ROW_COND[i];
         pulse_tick();
         cond = '0;
         rd_chk(7'h3C, ROW_EXP[i], "flag set");
         rd_chk(7'h3D, 16'h0000, "flag kept after read");
      end
      // condition persisting across a clearing read
      cond.overrange = 1'b1;
      pulse_tick();
      rd_chk(7'h3C, 16'h0010, "overrange set");
      rd_chk(7'h3C, 16'h0000, "overrange not cleared");
      pulse_tick();
      rd_chk(7'h3C, 16'h0010, "overrange not reset");
      // tick one cycle after a clearing read
      fork
         rd_chk(7'h3C, 16'h0000, "cleared before tick");
         begin
            repeat (2) @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
         end
      join
      rd_chk(7'h3C, 16'h0010, "set after clearing read");
      // tick on the very edge of a clearing read, set wins
      fork
         rd_chk(7'h3C, 16'h0000, "read beside tick");
         pulse_tick();
      join
      rd_chk(7'h3C, 16'h0010, "set over clear");
      // supply flag drops without a read, sticky flag stays
      cond.supply_hi = 1'b1;
      pulse_tick();
      cond = '0;
      pulse_tick();
      rd_chk(7'h3C, 16'h0010, "live vs sticky");
      // writes never touch status
      dst_host_model_inst.wr(7'h3C, 8'hFF);
      dst_host_model_inst.wr(7'h3D, 8'hFF);
      rd_chk(7'h3C, 16'h0000, "status written");
      // clock enable low freezes flags and control
      ce = 1'b0;
      cond.overrange = 1'b1;
      pulse_tick();
      dst_host_model_inst.wr(7'h35, 8'h02);
      ce = 1'b1;
      cond = '0;
      chk(ctrl, dst_pkg::MISC_RESET, "frozen control");
      rd_chk(7'h3C, 16'h0000, "frozen flags");
      // memory test failing, then self-test failing on three axes
      mem_fail = 1'b1;
      run_job(1'b1, 8'h08);
      mem_fail = 1'b0;
      rd_chk(7'h3C, 16'h0040, "checksum flag");
      st_res = 6'b101001;
      run_job(1'b0, 8'h04);
      rd_chk(7'h3D, 16'hA420, "self-test flags");
      rd_chk(7'h34, dst_pkg::MISC_RESET, "misc after jobs");
      pulse_tick();
      rd_chk(7'h3C, 16'hA460, "job results persist");
      // manual self-test sequence through the host
      dst_host_model_inst.manual_setup(rd_d, ok);
      chk({15'h0000, ok}, 16'h0001, "baseline answer");
      for (int k = 0; k < 3; k++) begin
         dst_host_model_inst.manual_phase(STIM_CODE[k], rd_d, ok);
         chk(rd_d, 16'h0000, "unmapped rate read");
         chk({15'h0000, ok}, 16'h0001, "rate answer");
         chk({14'h0000, stim_neg, stim_pos}, {8'h00, STIM_CODE[k]}, "stimulus");
         chk(ctrl, {6'h00, STIM_CODE[k][1:0], 8'h06}, "misc stimulus bits");
      end
      // reset in mid-run drops flags, job results and stimulus
      dst_host_model_inst.wr(7'h35, 8'h01);
      cond.overrange = 1'b1;
      pulse_tick();
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      cond = '0;
      chk(ctrl, dst_pkg::MISC_RESET, "misc after reset");
      chk({14'h0000, stim_neg, stim_pos}, 16'h0000, "stimulus after reset");
      rd_chk(7'h3C, 16'h0000, "status after reset");
      pulse_tick();
      rd_chk(7'h3C, 16'h0000, "job results after reset");
      tally_and_finish();
   end
endmodule // tb_dst_diag_status
